// ---- design/dpt_channel.sv ----
// dpt_channel: one pwm channel with clock divider, down counter and output
`timescale 1ns/1ps
`default_nettype none
module dpt_channel (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      clk_en,
  // settings
  input  wire logic                      psc_tick,
  input  wire logic [2:0]                div_sel,
  input  wire logic                      run_enable,
  input  wire logic                      reload_mode,
  input  wire logic [15:0]               reload_value,
  input  wire logic [15:0]               compare_value,
  // results
  output logic      [15:0]               live_count,
  output logic                           zero_pulse,
  output logic                           pwm_out
);

  // ----------------------------------------------------------------
  // divider stage
  // ----------------------------------------------------------------
  logic [3:0]                  div_cnt_r;
  logic [15:0]                 cmp_act_r;
  logic                        unit_tick;
  dpt_pkg::dpt_ch_state_t      state_r;

  // divide the prescaler tick by 1, 2, 4, 8 or 16
  function automatic logic [3:0] div_limit(input logic [2:0] sel);
    case (sel)
      dpt_pkg::DIV_BY2:  div_limit = 4'h1;
      dpt_pkg::DIV_BY4:  div_limit = 4'h3;
      dpt_pkg::DIV_BY8:  div_limit = 4'h7;
      dpt_pkg::DIV_BY16: div_limit = 4'hf;
      default:           div_limit = 4'h0;
    endcase
  endfunction : div_limit

  assign unit_tick = psc_tick && (div_cnt_r >= div_limit(div_sel));

  // divider counter, restarts while stopped so a run starts clean
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      div_cnt_r <= 4'h0;
    end else if (clk_en) begin
      if (!run_enable || unit_tick) begin
        div_cnt_r <= 4'h0;
      end else if (psc_tick) begin
        div_cnt_r <= div_cnt_r + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // down counter; reload and compare latch only at period boundary
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r    <= dpt_pkg::CH_IDLE;
      live_count <= 16'h0000;
      cmp_act_r  <= 16'h0000;
      zero_pulse <= 1'b0;
    end else if (clk_en) begin
      zero_pulse <= 1'b0;
      case (state_r)
        dpt_pkg::CH_IDLE: begin
          if (run_enable) begin
            live_count <= reload_value;
            cmp_act_r  <= compare_value;
            state_r    <= dpt_pkg::CH_RUN;
          end
        end
        dpt_pkg::CH_RUN: begin
          if (!run_enable) begin
            state_r <= dpt_pkg::CH_IDLE;
          end else if (unit_tick) begin
            if (live_count == 16'h0000) begin
              // new settings enter here and at the start from CH_IDLE, never mid period
              live_count <= reload_value;
              cmp_act_r  <= compare_value;
              if (!reload_mode) begin
                state_r <= dpt_pkg::CH_DONE;
              end
            end else begin
              live_count <= live_count - 16'h0001;
              if (live_count == 16'h0001) begin
                zero_pulse <= 1'b1;
              end
            end
          end
        end
        dpt_pkg::CH_DONE: begin
          // one shot finished; stays until run is dropped
          if (!run_enable) begin
            state_r <= dpt_pkg::CH_IDLE;
          end
        end
        default: state_r <= dpt_pkg::CH_IDLE;
      endcase
    end
  end

  // output high while count at or below compare; covers cmp >= period too
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pwm_out <= 1'b0;
    end else if (clk_en) begin
      pwm_out <= (state_r == dpt_pkg::CH_RUN) && (live_count <= cmp_act_r);
    end
  end

endmodule : dpt_channel
`default_nettype wire

// ---- design/dpt_core.sv ----
// dpt_core: dual pwm timer with apb register file, prescaler and interrupt
//
// Operation
// - channel 0 run enable at bit 0 stops the counter when clear and runs it when set.
// - each channel holds a 16-bit reload value that sets the period length.
// - output frequency is source clock over prescale+1, over divider, over reload+1.
// - with compare below reload the output is high compare+1 units, low reload-compare units.
// - with compare at or above reload the output stays high the whole period.
// - compare of zero gives one high unit and reload low units.
// - a reload write applies from the next pwm cycle.
// - a compare write applies from the next pwm cycle.
// - each channel has a read-only live count register.
// - interrupt enable has channel 1 at bit 1 and channel 0 at bit 0.
// - a zero count sets the channel flag; writing one clears it, zero leaves it.
// - the 8-bit shared prescaler divides by value+1; zero stops both counters.
// - divider select 0,1,2,3,4 divides by 2,4,8,16,1.
// - mode bit clear is one shot, set is auto reload; its rising edge clears reload and compare.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module dpt_core (
  // clock, reset, enable
  input  wire logic                      ref_clk,
  input  wire logic                      sys_rst,
  input  wire logic                      clk_en,
  // apb slave
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  // pwm outputs and interrupt
  output logic                           ch0_pwm,
  output logic                           ch1_pwm,
  output logic                           irq
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  logic [7:0]            pair_prescaler_r;
  logic [2:0]            ch0_divider_select_r;
  logic [2:0]            ch1_divider_select_r;
  logic                  ch0_run_enable_r;
  logic                  ch1_run_enable_r;
  logic                  ch0_reload_mode_r;
  logic                  ch1_reload_mode_r;
  logic [15:0]           ch0_reload_value_r;
  logic [15:0]           ch1_reload_value_r;
  logic [15:0]           ch0_compare_value_r;
  logic [15:0]           ch1_compare_value_r;
  logic [1:0]            timer_irq_enable_r;
  logic [1:0]            timer_irq_flags_r;
  logic [7:0]            psc_cnt_r;
  logic                  psc_tick;
  logic [15:0]           ch0_live_count;
  logic [15:0]           ch1_live_count;
  logic                  ch0_zero;
  logic                  ch1_zero;
  logic                  wr_en;
  logic                  rd_en;
  logic                  addr_ok;
  logic                  ch0_mode_rise;
  logic                  ch1_mode_rise;

  // ----------------------------------------------------------------
  // apb decode: zero wait states, unmapped addresses give pslverr
  // ----------------------------------------------------------------
  function automatic logic is_mapped(input logic [11:0] a);
    case (a)
      dpt_pkg::PRESCALE_OFF, dpt_pkg::DIVIDER_OFF, dpt_pkg::CONTROL_OFF,
      dpt_pkg::CH0_RELOAD_OFF, dpt_pkg::CH0_CMP_OFF, dpt_pkg::CH0_CNT_OFF,
      dpt_pkg::CH1_RELOAD_OFF, dpt_pkg::CH1_CMP_OFF, dpt_pkg::CH1_CNT_OFF,
      dpt_pkg::IRQ_EN_OFF, dpt_pkg::IRQ_FLAG_OFF: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  assign addr_ok = is_mapped(paddr);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  // a frozen block takes no writes; the access still completes without pslverr, so it is lost silently
  assign wr_en   = psel && penable && pwrite && addr_ok && clk_en;
  // read data is state as well, so it freezes with the rest of the block
  assign rd_en   = psel && !penable && !pwrite && clk_en;

  // mode bit rising edges, seen from the written value
  assign ch0_mode_rise = wr_en && (paddr == dpt_pkg::CONTROL_OFF)
                         && pwdata[dpt_pkg::CH0_MODE_BIT] && !ch0_reload_mode_r;
  assign ch1_mode_rise = wr_en && (paddr == dpt_pkg::CONTROL_OFF)
                         && pwdata[dpt_pkg::CH1_MODE_BIT] && !ch1_reload_mode_r;

  // ----------------------------------------------------------------
  // clock and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pair_prescaler_r     <= dpt_pkg::REG_RESET[7:0];
      ch0_divider_select_r <= dpt_pkg::REG_RESET[2:0];
      ch1_divider_select_r <= dpt_pkg::REG_RESET[2:0];
      ch0_run_enable_r     <= 1'b0;
      ch1_run_enable_r     <= 1'b0;
      ch0_reload_mode_r    <= 1'b0;
      ch1_reload_mode_r    <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        dpt_pkg::PRESCALE_OFF:
          pair_prescaler_r <= pwdata[dpt_pkg::PSC_LSB +: dpt_pkg::PSC_W];
        dpt_pkg::DIVIDER_OFF: begin
          ch0_divider_select_r <= pwdata[dpt_pkg::DIV0_LSB +: dpt_pkg::DIV_W];
          ch1_divider_select_r <= pwdata[dpt_pkg::DIV1_LSB +: dpt_pkg::DIV_W];
        end
        dpt_pkg::CONTROL_OFF: begin
          ch0_run_enable_r  <= pwdata[dpt_pkg::CH0_RUN_BIT];
          ch1_run_enable_r  <= pwdata[dpt_pkg::CH1_RUN_BIT];
          ch0_reload_mode_r <= pwdata[dpt_pkg::CH0_MODE_BIT];
          ch1_reload_mode_r <= pwdata[dpt_pkg::CH1_MODE_BIT];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // reload and compare values, cleared on a mode bit rising edge
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ch0_reload_value_r  <= dpt_pkg::REG_RESET[15:0];
      ch1_reload_value_r  <= dpt_pkg::REG_RESET[15:0];
      ch0_compare_value_r <= dpt_pkg::REG_RESET[15:0];
      ch1_compare_value_r <= dpt_pkg::REG_RESET[15:0];
    end else if (wr_en) begin
      if (ch0_mode_rise) begin
        ch0_reload_value_r  <= 16'h0000;
        ch0_compare_value_r <= 16'h0000;
      end
      if (ch1_mode_rise) begin
        ch1_reload_value_r  <= 16'h0000;
        ch1_compare_value_r <= 16'h0000;
      end
      case (paddr)
        dpt_pkg::CH0_RELOAD_OFF: ch0_reload_value_r  <= pwdata[15:0];
        dpt_pkg::CH1_RELOAD_OFF: ch1_reload_value_r  <= pwdata[15:0];
        dpt_pkg::CH0_CMP_OFF:    ch0_compare_value_r <= pwdata[15:0];
        dpt_pkg::CH1_CMP_OFF:    ch1_compare_value_r <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt enable and sticky flags
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      timer_irq_enable_r <= 2'h0;
    end else if (wr_en && (paddr == dpt_pkg::IRQ_EN_OFF)) begin
      timer_irq_enable_r <= pwdata[1:0];
    end
  end

  // set beats a simultaneous write-one clear so no zero event is lost
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      timer_irq_flags_r <= 2'h0;
    end else if (clk_en) begin
      for (int i = 0; i < 2; i++) begin
        if ((i == 0) ? ch0_zero : ch1_zero) begin
          timer_irq_flags_r[i] <= 1'b1;
        end else if (wr_en && (paddr == dpt_pkg::IRQ_FLAG_OFF) && pwdata[i]) begin
          timer_irq_flags_r[i] <= 1'b0;
        end
      end
    end
  end

  // level request while any enabled flag stands
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(timer_irq_flags_r & timer_irq_enable_r);
    end
  end

  // ----------------------------------------------------------------
  // shared prescaler: divide by value+1, zero holds it stopped
  // ----------------------------------------------------------------
  assign psc_tick = (pair_prescaler_r != 8'h00) && (psc_cnt_r == pair_prescaler_r);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      psc_cnt_r <= 8'h00;
    end else if (clk_en) begin
      if (pair_prescaler_r == 8'h00 || psc_tick) begin
        psc_cnt_r <= 8'h00;
      end else begin
        psc_cnt_r <= psc_cnt_r + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // read data, registered in the setup phase
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        dpt_pkg::PRESCALE_OFF:   prdata <= {24'h00_0000, pair_prescaler_r};
        dpt_pkg::DIVIDER_OFF:    prdata <= {25'h000_0000, ch1_divider_select_r, 1'b0,
                                            ch0_divider_select_r};
        dpt_pkg::CONTROL_OFF:    prdata <= {20'h0_0000, ch1_reload_mode_r, 2'b00,
                                            ch1_run_enable_r, 4'h0, ch0_reload_mode_r,
                                            2'b00, ch0_run_enable_r};
        dpt_pkg::CH0_RELOAD_OFF: prdata <= {16'h0000, ch0_reload_value_r};
        dpt_pkg::CH0_CMP_OFF:    prdata <= {16'h0000, ch0_compare_value_r};
        dpt_pkg::CH0_CNT_OFF:    prdata <= {16'h0000, ch0_live_count};
        dpt_pkg::CH1_RELOAD_OFF: prdata <= {16'h0000, ch1_reload_value_r};
        dpt_pkg::CH1_CMP_OFF:    prdata <= {16'h0000, ch1_compare_value_r};
        dpt_pkg::CH1_CNT_OFF:    prdata <= {16'h0000, ch1_live_count};
        dpt_pkg::IRQ_EN_OFF:     prdata <= {30'h0000_0000, timer_irq_enable_r};
        dpt_pkg::IRQ_FLAG_OFF:   prdata <= {30'h0000_0000, timer_irq_flags_r};
        default:                 prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  dpt_channel u_ch0 (
    .ref_clk       (ref_clk),
    .sys_rst       (sys_rst),
    .clk_en        (clk_en),
    .psc_tick      (psc_tick),
    .div_sel       (ch0_divider_select_r),
    .run_enable    (ch0_run_enable_r),
    .reload_mode   (ch0_reload_mode_r),
    .reload_value  (ch0_reload_value_r),
    .compare_value (ch0_compare_value_r),
    .live_count    (ch0_live_count),
    .zero_pulse    (ch0_zero),
    .pwm_out       (ch0_pwm)
  );

  dpt_channel u_ch1 (
    .ref_clk       (ref_clk),
    .sys_rst       (sys_rst),
    .clk_en        (clk_en),
    .psc_tick      (psc_tick),
    .div_sel       (ch1_divider_select_r),
    .run_enable    (ch1_run_enable_r),
    .reload_mode   (ch1_reload_mode_r),
    .reload_value  (ch1_reload_value_r),
    .compare_value (ch1_compare_value_r),
    .live_count    (ch1_live_count),
    .zero_pulse    (ch1_zero),
    .pwm_out       (ch1_pwm)
  );

endmodule : dpt_core
`default_nettype wire

// ---- design/dpt_pkg.sv ----
// dpt_pkg: register map, field positions and constants of the dual pwm timer core
package dpt_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] PRESCALE_OFF  = 12'h000;
  localparam logic [11:0] DIVIDER_OFF   = 12'h004;
  localparam logic [11:0] CONTROL_OFF   = 12'h008;
  localparam logic [11:0] CH0_RELOAD_OFF = 12'h00c;
  localparam logic [11:0] CH0_CMP_OFF   = 12'h010;
  localparam logic [11:0] CH0_CNT_OFF   = 12'h014;
  localparam logic [11:0] CH1_RELOAD_OFF = 12'h018;
  localparam logic [11:0] CH1_CMP_OFF   = 12'h01c;
  localparam logic [11:0] CH1_CNT_OFF   = 12'h020;
  localparam logic [11:0] IRQ_EN_OFF    = 12'h040;
  localparam logic [11:0] IRQ_FLAG_OFF  = 12'h044;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PSC_LSB       = 0;
  localparam int PSC_W         = 8;
  localparam int DIV0_LSB      = 0;
  localparam int DIV1_LSB      = 4;
  localparam int DIV_W         = 3;
  localparam int CH0_RUN_BIT   = 0;
  localparam int CH0_MODE_BIT  = 3;
  localparam int CH1_RUN_BIT   = 8;
  localparam int CH1_MODE_BIT  = 11;
  localparam int CNT_W         = 16;

  // ----------------------------------------------------------------
  // reset values and divider codes
  // ----------------------------------------------------------------
  localparam logic [31:0] REG_RESET = 32'h0000_0000;
  localparam logic [2:0]  DIV_BY2   = 3'h0;
  localparam logic [2:0]  DIV_BY4   = 3'h1;
  localparam logic [2:0]  DIV_BY8   = 3'h2;
  localparam logic [2:0]  DIV_BY16  = 3'h3;
  localparam logic [2:0]  DIV_BY1   = 3'h4;

  typedef enum logic [1:0] {CH_IDLE, CH_RUN, CH_DONE} dpt_ch_state_t;

endpackage : dpt_pkg

// ---- tb/dpt_core_asserts.sv ----
// dpt_core_asserts: port level checks of the dual pwm timer core
`timescale 1ns/1ps
`default_nettype none
module dpt_core_asserts (
  // clock, reset, enable
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  // apb slave
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // pwm outputs and interrupt
  input wire logic        ch0_pwm,
  input wire logic        ch1_pwm,
  input wire logic        irq
);
  // ------------------------------------------------
  // helper decode
  // ------------------------------------------------
  // a write one cycle back may still move irq, so hold checks skip it
  logic mapped;
  logic wr_now;
  logic wr_q;
  assign mapped = paddr inside {dpt_pkg::PRESCALE_OFF, dpt_pkg::DIVIDER_OFF,
    dpt_pkg::CONTROL_OFF, dpt_pkg::CH0_RELOAD_OFF, dpt_pkg::CH0_CMP_OFF, dpt_pkg::CH0_CNT_OFF,
    dpt_pkg::CH1_RELOAD_OFF, dpt_pkg::CH1_CMP_OFF, dpt_pkg::CH1_CNT_OFF,
    dpt_pkg::IRQ_EN_OFF, dpt_pkg::IRQ_FLAG_OFF};
  assign wr_now = psel && penable && pwrite;
  // previous write strobe
  always_ff @(posedge ref_clk) begin
    wr_q <= wr_now;
  end

  // ------------------------------------------------
  // properties
  // ------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  sequence reg_wr(logic [11:0] a);
    wr_now && clk_en && paddr == a;
  endsequence

  run0_stop_a:
    assert property (reg_wr(dpt_pkg::CONTROL_OFF) ##0 !pwdata[0] |-> ##3 !ch0_pwm)
    else $error("channel 0 output high after stop");
  run1_stop_a:
    assert property (reg_wr(dpt_pkg::CONTROL_OFF) ##0 !pwdata[8] |-> ##3 !ch1_pwm)
    else $error("channel 1 output high after stop");
  psc_halt_a:
    assert property (reg_wr(dpt_pkg::PRESCALE_OFF) ##0 pwdata[7:0] == 8'h00
      |-> ##4 ($stable(ch0_pwm) && $stable(ch1_pwm)) [*3])
    else $error("outputs moved with prescaler at zero");
  irq_mask_a:
    assert property (reg_wr(dpt_pkg::IRQ_EN_OFF) ##0 pwdata[1:0] == 2'b00 |-> ##2 !irq)
    else $error("irq high with both enables clear");
  irq_hold_a:
    assert property (irq && !wr_now && !wr_q |=> irq)
    else $error("irq dropped without a register write");
  err_set_a:
    assert property (psel && penable && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  err_clr_a:
    assert property (psel && penable && mapped |-> !pslverr)
    else $error("error on mapped access");
  bad_read_a:
    assert property (psel && !penable && !pwrite && clk_en && !mapped |=> prdata == 32'h0000_0000)
    else $error("unmapped read returned data");
  reset_quiet_a:
    assert property ($fell(sys_rst) |-> !irq && !ch0_pwm && !ch1_pwm && prdata == 32'h0000_0000)
    else $error("outputs not quiet after reset");
  freeze_hold_a:
    assert property (!clk_en |=> $stable(ch0_pwm) && $stable(ch1_pwm) && $stable(irq)
      && $stable(prdata))
    else $error("outputs moved with clock enable low");
  irq_seen_c: cover property ($rose(irq));
endmodule : dpt_core_asserts

bind dpt_core dpt_core_asserts dpt_core_asserts_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ch0_pwm(ch0_pwm),
  .ch1_pwm(ch1_pwm), .irq(irq));
`default_nettype wire

// ---- tb/dpt_core_tb.sv ----
// dpt_core_tb: register and waveform tests of the dual pwm timer core
`timescale 1ns/1ps
`default_nettype none
module dpt_core_tb;
  // ------------------------------------------------
  // signals and design
  // ------------------------------------------------
  logic        ref_clk, sys_rst, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        ch0_pwm, ch1_pwm, irq, err;
  int          num_errors, check_count, cyc, hi_n, lo_n, last_hi, last_lo;
  time         t0;
  int          div_of [5] = '{2, 4, 8, 16, 1};
  logic [11:0] regs [11] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014,
                             12'h018, 12'h01c, 12'h020, 12'h040, 12'h044};

  dpt_core dpt_core_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ch0_pwm(ch0_pwm), .ch1_pwm(ch1_pwm), .irq(irq));

  // free running clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // widths in clocks of the last high and low stretch of channel 0
  always @(posedge ref_clk) begin
    hi_n <= (ch0_pwm === 1'b1) ? hi_n + 1 : 0;
    lo_n <= (ch0_pwm === 1'b1) ? 0 : lo_n + 1;
    if (ch0_pwm === 1'b1 && lo_n != 0) last_lo <= lo_n;
    if (ch0_pwm !== 1'b1 && hi_n != 0) last_hi <= hi_n;
  end

  // hang guard; the slowest divider test needs well under this
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      wrap_up();
    end
  end

  // ------------------------------------------------
  // tasks
  // ------------------------------------------------
  task automatic wrap_up();
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd_check(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rd_check

  task automatic clks(input int k);
    repeat (k) @(posedge ref_clk);
  endtask : clks

  // ------------------------------------------------
  // test sequence
  // ------------------------------------------------
  initial begin
    {sys_rst, clk_en, psel, penable, pwrite} = 5'b11000;
    {paddr, pwdata} = '0;
    {num_errors, check_count, cyc, hi_n, lo_n, last_hi, last_lo} = '0;
    clks(12);
    sys_rst <= 1'b0;
    foreach (regs[i]) rd_check(regs[i], 32'h0000_0000);
    apb(1'b1, 12'h03c, 32'h0000_00ff);
    check(32'(err), 32'h0000_0001);
    apb(1'b0, 12'h024, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    wr(12'h00c, 32'hffff_ffff);
    rd_check(12'h00c, 32'h0000_ffff);
    wr(12'h008, 32'h0000_0808);
    rd_check(12'h00c, 32'h0000_0000);
    // unit of four clocks on both channels, then start them
    wr(12'h000, 32'h0000_0003);
    wr(12'h004, 32'h0000_0044);
    wr(12'h00c, 32'h0000_0004);
    wr(12'h010, 32'h0000_0001);
    wr(12'h018, 32'h0000_0003);
    wr(12'h01c, 32'h0000_0001);
    wr(12'h008, 32'h0000_0909);
    // compare written in the low stretch only counts from the next period
    @(negedge ch0_pwm);
    wr(12'h010, 32'h0000_0000);
    @(negedge ch0_pwm);
    clks(2);
    check(32'(last_hi), 32'd8);
    check(32'(last_lo), 32'd12);
    @(negedge ch0_pwm);
    clks(2);
    check(32'(last_hi), 32'd4);
    check(32'(last_lo), 32'd16);
    // reload written mid period only counts from the next period
    wr(12'h014, 32'h0000_0000);
    @(negedge ch0_pwm);
    wr(12'h00c, 32'h0000_0006);
    @(posedge ch0_pwm);
    clks(2);
    check(32'(last_lo), 32'd16);
    @(posedge ch0_pwm);
    clks(2);
    check(32'(last_lo), 32'd24);
    // both flags are set by now; exercise enables and clearing
    wr(12'h040, 32'h0000_0001);
    clks(3);
    check(32'(irq), 32'h0000_0001);
    rd_check(12'h044, 32'h0000_0003);
    wr(12'h044, 32'h0000_0000);
    rd_check(12'h044, 32'h0000_0003);
    wr(12'h040, 32'h0000_0000);
    clks(2);
    check(32'(irq), 32'h0000_0000);
    wr(12'h040, 32'h0000_0002);
    clks(3);
    check(32'(irq), 32'h0000_0001);
    rd_check(12'h040, 32'h0000_0002);
    wr(12'h040, 32'h0000_0000);
    // compare at reload keeps the output high
    wr(12'h010, 32'h0000_0006);
    clks(120);
    check(32'(hi_n > 60), 32'h0000_0001);
    // prescaler zero freezes the counters; the count stays read only
    wr(12'h000, 32'h0000_0000);
    apb(1'b0, 12'h014, 32'h0000_0000);
    t0 = rd;
    clks(20);
    rd_check(12'h014, 32'(t0));
    wr(12'h014, 32'h0000_ffff);
    rd_check(12'h014, 32'(t0));
    check(32'(t0 <= 6), 32'h0000_0001);
    // every divider code on channel 1, prescaler dividing by two
    wr(12'h000, 32'h0000_0001);
    for (int c = 0; c < 5; c++) begin
      wr(12'h004, (32'(c) << 4) | 32'h0000_0004);
      @(posedge ch1_pwm);
      @(posedge ch1_pwm);
      t0 = $time;
      @(posedge ch1_pwm);
      check(32'(($time - t0) / 50), 32'(2 * div_of[c] * 4));
    end
    // stop both channels, then clear both flags
    wr(12'h008, 32'h0000_0808);
    clks(4);
    check(32'({ch1_pwm, ch0_pwm}), 32'h0000_0000);
    wr(12'h044, 32'h0000_0003);
    rd_check(12'h044, 32'h0000_0000);
    // one shot on channel 0: a single period, always high, then it stays low
    wr(12'h008, 32'h0000_0001);
    clks(40);
    check(32'(ch0_pwm), 32'h0000_0000);
    rd_check(12'h044, 32'h0000_0001);
    // a write while the clock enable is low must be dropped
    clk_en <= 1'b0;
    wr(12'h040, 32'h0000_0003);
    clk_en <= 1'b1;
    rd_check(12'h040, 32'h0000_0000);
    wrap_up();
  end
endmodule : dpt_core_tb
`default_nettype wire
